/* File: rtl/esah_regs.svh */
/*
  register indices, field positions, reset values and timing counts for the
  environmental status and alarm hierarchy.
  assumes a single 20 MHz clock; included by bare name.
*/
`ifndef ESAH_REGS_SVH
`define ESAH_REGS_SVH

`define ESAH_CLK_HZ          20000000
`define ESAH_SEC_CYCLES      (`ESAH_CLK_HZ / 1)

// register select codes for the host command port
`define ESAH_R_VOLT_COND     5'h00
`define ESAH_R_VOLT_EVENT    5'h01
`define ESAH_R_VOLT_ENAB     5'h02
`define ESAH_R_TEMP_COND     5'h03
`define ESAH_R_TEMP_EVENT    5'h04
`define ESAH_R_TEMP_ENAB     5'h05
`define ESAH_R_FAN_COND      5'h06
`define ESAH_R_FAN_EVENT     5'h07
`define ESAH_R_FAN_ENAB      5'h08
`define ESAH_R_TIME_COND     5'h09
`define ESAH_R_TIME_EVENT    5'h0a
`define ESAH_R_TIME_ENAB     5'h0b
`define ESAH_R_BP_COND       5'h0c
`define ESAH_R_BP_EVENT      5'h0d
`define ESAH_R_BP_ENAB       5'h0e
`define ESAH_R_QUES_COND     5'h0f
`define ESAH_R_QUES_EVENT    5'h10
`define ESAH_R_QUES_ENAB     5'h11
`define ESAH_R_SRE           5'h12
`define ESAH_R_STB           5'h13
`define ESAH_R_FILT_LIMIT    5'h14
`define ESAH_R_FILT_ELAPSED  5'h15
`define ESAH_R_FILT_CLEAR    5'h16
`define ESAH_R_POWERON_LO    5'h17
`define ESAH_R_POWERON_HI    5'h18
`define ESAH_R_FILT_REF_LO   5'h19
`define ESAH_R_FILT_REF_HI   5'h1a

// field positions
`define ESAH_VOLT_MASK       16'h007f
`define ESAH_TEMP_MASK       16'h3fff
`define ESAH_FAN_MASK        16'h000f
`define ESAH_TIME_MASK       16'h0007
`define ESAH_BP_MASK         16'h03ff
`define ESAH_TIME_FILT_BIT   2
`define ESAH_QB_VOLT         0
`define ESAH_QB_TIME         2
`define ESAH_QB_TEMP         4
`define ESAH_QB_FAN          5
`define ESAH_QB_BP           9
`define ESAH_STB_QUES_BIT    3

`define ESAH_RST_EVENT       16'h0000
`define ESAH_RST_ENAB        16'h0000
`define ESAH_RST_SRE         8'h00

`endif

/* File: rtl/esah_pkg.sv */
/*
  types shared by the status hierarchy: the host command port bundle
  and its answer bundle.
  assumes esah_regs.svh supplies the numbers.
*/
package esah_pkg;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [4:0]  sel;
    logic [31:0] wdata;
  } esah_cmd_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } esah_rsp_t;

endpackage : esah_pkg

/* File: rtl/esah_attr.sv */
/*
  one attribute level: live condition, latched event with clear on read,
  enable, and the summary bit.
  assumes cond_in is already synchronous to clock.
*/
module esah_attr #(
  parameter int W = 16
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] cond_in,
  input  wire logic         rd_event,
  input  wire logic         wr_enab,
  input  wire logic [W-1:0] wdata,
  output logic      [W-1:0] cond_ff,
  output logic      [W-1:0] event_ff,
  output logic      [W-1:0] enab_ff,
  output logic              summary
);

  logic [W-1:0] nxt_event;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cond_ff <= '0;
    end else begin
      cond_ff <= cond_in; // RULE_06
    end
  end

  // set on a rising condition wins over a read clear in the same cycle
  always_comb begin
    nxt_event = rd_event ? '0 : event_ff; // RULE_08
    nxt_event = nxt_event | (cond_in & ~cond_ff); // RULE_07
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      event_ff <= '0; // RULE_22
    end else begin
      event_ff <= nxt_event; // RULE_05
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      enab_ff <= '0; // RULE_22
    end else if (wr_enab) begin
      enab_ff <= wdata;
    end
  end

  assign summary = |(event_ff & enab_ff); // RULE_09

endmodule : esah_attr

/* File: rtl/esah_top.sv */
/*
  environmental status and alarm hierarchy: attribute registers, the
  questionable summary level, status byte, service request interrupt and
  the filter service timer.
  assumes alarm inputs are asynchronous levels from the monitor; the host
  command port is synchronous to clock.
*/
// Operation
// (RULE_01) temperature bits 0-12 per slot rise over limit, bit 13 ambient.
// (RULE_02) fan bits 1-3 per fan out of tolerance, bit 0 any fan.
// (RULE_03) time bits: 0 present, 1 cumulative, 2 filter service over limit.
// (RULE_04) backplane: 0 bus error, 1 sysfail, 2 acfail, 3-9 ack counts.
// (RULE_05) event registers use the same bit layout as their condition.
// (RULE_06) condition bits are live; event bits stay latched.
// (RULE_07) event bit sets only on a condition rising edge.
// (RULE_08) reading an event register returns it and clears it.
// (RULE_09) summary bit is OR of event AND enable.
// (RULE_10) questionable bits 0 volt, 2 time, 4 temp, 5 fan, 9 backplane.
// (RULE_11) questionable condition reads no more than 565.
// (RULE_12) questionable event latches rising summaries, clears on read.
// (RULE_13) status byte bit 3 is OR of enabled questionable events.
// (RULE_14) interrupt when an enabled status byte bit rises.
// (RULE_15) power-on counter ticks each second while power is on.
// (RULE_16) filter elapsed time is counter minus stored reference.
// (RULE_17) elapsed over limit sets time bit 2.
// (RULE_18) time condition bit 2 stays while alarm active.
// (RULE_19) filter clear copies counter into reference; elapsed reads 0.
// (RULE_20) host should clear filter alarm after cleaning and power-up.
// (RULE_21) voltage bits 0-6 for seven supplies, higher bits zero.
// (RULE_22) reset clears all event and enable registers and the SRE.
`include "esah_regs.svh"

module esah_top #(
  parameter int          SEC_CYCLES = `ESAH_SEC_CYCLES,
  parameter logic [31:0] REF_INIT   = 32'h0000_0000,
  parameter logic [31:0] LIMIT_INIT = 32'hffff_ffff
) (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic [6:0]         supply_out_tol,
  input  wire logic [12:0]        slot_rise_over,
  input  wire logic               ambient_over,
  input  wire logic [2:0]         fan_out_tol,
  input  wire logic               present_time_over,
  input  wire logic               cumulative_time_over,
  input  wire logic               bus_err_over,
  input  wire logic               sysfail_asserted,
  input  wire logic               acfail_asserted,
  input  wire logic [6:0]         iack_over,
  input  wire logic               mainframe_power_on,
  input  wire logic [7:0]         stb_other_bits,
  input  wire esah_pkg::esah_cmd_t cmd,
  output esah_pkg::esah_rsp_t     rsp_ff,
  output logic                    irq_ff,
  output logic [7:0]              status_byte_ff,
  output logic [31:0]             filt_ref_ff
);

  localparam int NA = 5;

  // two-stage synchronisers on every asynchronous pin
  // stb_other_bits is same-clock logic and stays out of this chain
  logic [36:0] pins_in;
  logic [36:0] pins_s1_ff;
  logic [36:0] pins_s2_ff;

  assign pins_in = {mainframe_power_on, iack_over, acfail_asserted,
                    sysfail_asserted, bus_err_over, cumulative_time_over,
                    present_time_over, fan_out_tol, ambient_over,
                    slot_rise_over, supply_out_tol};

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pins_s1_ff <= '0;
      pins_s2_ff <= '0;
    end else begin
      pins_s1_ff <= pins_in;
      pins_s2_ff <= pins_s1_ff;
    end
  end

  logic [6:0]  s_supply;
  logic [12:0] s_slot;
  logic        s_amb;
  logic [2:0]  s_fan;
  logic        s_pres;
  logic        s_cum;
  logic        s_berr;
  logic        s_sysf;
  logic        s_acf;
  logic [6:0]  s_iack;
  logic        s_power;

  assign {s_power, s_iack, s_acf, s_sysf, s_berr, s_cum, s_pres, s_fan,
          s_amb, s_slot, s_supply} = pins_s2_ff;

  // filter service timer
  logic [$clog2(SEC_CYCLES+1)-1:0] presc_ff;
  logic        sec_tick;
  logic [31:0] poweron_ff;
  logic [31:0] filt_limit_ff;
  logic [31:0] filt_elapsed;
  logic        filt_alarm;

  assign sec_tick = s_power &&
                    (presc_ff == ($clog2(SEC_CYCLES+1))'(SEC_CYCLES - 1));

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      presc_ff <= '0;
    end else if (!s_power || sec_tick) begin
      presc_ff <= '0;
    end else begin
      presc_ff <= presc_ff + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      poweron_ff <= '0;
    end else if (sec_tick) begin
      poweron_ff <= poweron_ff + 32'h1; // RULE_15
    end
  end

  assign filt_elapsed = poweron_ff - filt_ref_ff; // RULE_16
  assign filt_alarm   = filt_elapsed > filt_limit_ff; // RULE_17

  // host command decode
  logic wr_cmd;
  logic rd_cmd;
  assign wr_cmd = cmd.req && cmd.wr;
  assign rd_cmd = cmd.req && !cmd.wr;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      filt_ref_ff <= REF_INIT;
    end else if (wr_cmd && cmd.sel == `ESAH_R_FILT_CLEAR) begin
      filt_ref_ff <= poweron_ff; // RULE_19
    end else if (wr_cmd && cmd.sel == `ESAH_R_FILT_REF_LO) begin
      filt_ref_ff <= cmd.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      filt_limit_ff <= LIMIT_INIT;
    end else if (wr_cmd && cmd.sel == `ESAH_R_FILT_LIMIT) begin
      filt_limit_ff <= cmd.wdata;
    end
  end

  // attribute level
  logic [NA-1:0][15:0] a_cond_in;
  logic [NA-1:0][15:0] a_cond;
  logic [NA-1:0][15:0] a_event;
  logic [NA-1:0][15:0] a_enab;
  logic [NA-1:0]       a_sum;
  logic [NA-1:0][4:0]  a_base;

  assign a_cond_in[0] = {9'h0, s_supply}; // RULE_21
  assign a_cond_in[1] = {2'h0, s_amb, s_slot}; // RULE_01
  assign a_cond_in[2] = {12'h0, s_fan, |s_fan}; // RULE_02
  assign a_cond_in[3] = {13'h0, filt_alarm, s_cum, s_pres}; // RULE_03 RULE_18
  assign a_cond_in[4] = {6'h0, s_iack, s_acf, s_sysf, s_berr}; // RULE_04

  assign a_base[0] = `ESAH_R_VOLT_COND;
  assign a_base[1] = `ESAH_R_TEMP_COND;
  assign a_base[2] = `ESAH_R_FAN_COND;
  assign a_base[3] = `ESAH_R_TIME_COND;
  assign a_base[4] = `ESAH_R_BP_COND;

  genvar gi;
  generate
    for (gi = 0; gi < NA; gi++) begin : g_attr
      esah_attr #(.W(16)) u_attr (
        .clock    (clock),
        .rst_n    (rst_n),
        .cond_in  (a_cond_in[gi]),
        .rd_event (rd_cmd && cmd.sel == a_base[gi] + 5'h1),
        .wr_enab  (wr_cmd && cmd.sel == a_base[gi] + 5'h2),
        .wdata    (cmd.wdata[15:0]),
        .cond_ff  (a_cond[gi]),
        .event_ff (a_event[gi]),
        .enab_ff  (a_enab[gi]),
        .summary  (a_sum[gi])
      );
    end
  endgenerate

  // questionable level
  logic [15:0] q_cond_in;
  logic [15:0] q_cond;
  logic [15:0] q_event;
  logic [15:0] q_enab;
  logic        q_sum;

  always_comb begin
    q_cond_in = 16'h0000; // RULE_11
    q_cond_in[`ESAH_QB_VOLT] = a_sum[0]; // RULE_10
    q_cond_in[`ESAH_QB_TEMP] = a_sum[1];
    q_cond_in[`ESAH_QB_FAN]  = a_sum[2];
    q_cond_in[`ESAH_QB_TIME] = a_sum[3];
    q_cond_in[`ESAH_QB_BP]   = a_sum[4];
  end

  esah_attr #(.W(16)) u_ques (
    .clock    (clock),
    .rst_n    (rst_n),
    .cond_in  (q_cond_in),
    .rd_event (rd_cmd && cmd.sel == `ESAH_R_QUES_EVENT), // RULE_12
    .wr_enab  (wr_cmd && cmd.sel == `ESAH_R_QUES_ENAB),
    .wdata    (cmd.wdata[15:0]),
    .cond_ff  (q_cond),
    .event_ff (q_event),
    .enab_ff  (q_enab),
    .summary  (q_sum)
  );

  // status byte and service request
  logic [7:0] sre_ff;
  logic [7:0] nxt_stb;

  always_comb begin
    nxt_stb = stb_other_bits;
    nxt_stb[`ESAH_STB_QUES_BIT] = q_sum; // RULE_13
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sre_ff <= `ESAH_RST_SRE; // RULE_22
    end else if (wr_cmd && cmd.sel == `ESAH_R_SRE) begin
      sre_ff <= cmd.wdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      status_byte_ff <= 8'h00;
    end else begin
      status_byte_ff <= nxt_stb;
    end
  end

  // one-cycle pulse when any enabled status bit rises
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_stb & ~status_byte_ff & sre_ff); // RULE_14
    end
  end

  // read mux
  logic [31:0] nxt_rdata;
  int          k;

  always_comb begin
    nxt_rdata = 32'h0;
    for (k = 0; k < NA; k++) begin
      if (cmd.sel == a_base[k]) nxt_rdata = {16'h0, a_cond[k]};
      if (cmd.sel == a_base[k] + 5'h1) nxt_rdata = {16'h0, a_event[k]};
      if (cmd.sel == a_base[k] + 5'h2) nxt_rdata = {16'h0, a_enab[k]};
    end
    case (cmd.sel)
      `ESAH_R_QUES_COND:    nxt_rdata = {16'h0, q_cond};
      `ESAH_R_QUES_EVENT:   nxt_rdata = {16'h0, q_event};
      `ESAH_R_QUES_ENAB:    nxt_rdata = {16'h0, q_enab};
      `ESAH_R_SRE:          nxt_rdata = {24'h0, sre_ff};
      `ESAH_R_STB:          nxt_rdata = {24'h0, status_byte_ff};
      `ESAH_R_FILT_LIMIT:   nxt_rdata = filt_limit_ff;
      `ESAH_R_FILT_ELAPSED: nxt_rdata = filt_elapsed; // RULE_16
      `ESAH_R_POWERON_LO:   nxt_rdata = poweron_ff;
      `ESAH_R_FILT_REF_LO:  nxt_rdata = filt_ref_ff;
      default:              nxt_rdata = nxt_rdata;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.valid <= rd_cmd;
      rsp_ff.rdata <= rd_cmd ? nxt_rdata : 32'h0;
    end
  end

endmodule : esah_top

/* File: verif/esah_top_asserts.sv */
/* checker for the status hierarchy: answer timing, field widths,
   interrupt cause and the filter clear.
   assumes esah_top ports and the select codes of esah_regs.svh. */
`include "esah_regs.svh"
module esah_top_asserts (
  input wire logic                clock,
  input wire logic                rst_n,
  input wire logic                mainframe_power_on,
  input wire esah_pkg::esah_cmd_t cmd,
  input wire esah_pkg::esah_rsp_t rsp_ff,
  input wire logic                irq_ff,
  input wire logic [7:0]          status_byte_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sre_ff;
  // shadow of the service request enable as the host last wrote it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sre_ff <= 8'h00;
    end else if (cmd.req && cmd.wr && cmd.sel == `ESAH_R_SRE) begin
      sre_ff <= cmd.wdata[7:0];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_clear;
    !mainframe_power_on [*8] ##0
      (cmd.req && cmd.wr && cmd.sel == `ESAH_R_FILT_CLEAR);
  endsequence
  sequence s_elapsed;
    cmd.req && !cmd.wr && cmd.sel == `ESAH_R_FILT_ELAPSED;
  endsequence
  property p_bits(logic [4:0] s, logic [31:0] m);
    rsp_ff.valid && $past(cmd.sel) == s |-> (rsp_ff.rdata & ~m) == 32'h0;
  endproperty
  a_rsp_answer: assert property (cmd.req && !cmd.wr |=> rsp_ff.valid)
    else $error("read got no answer");
  a_rsp_quiet: assert property (!(cmd.req && !cmd.wr) |=> !rsp_ff.valid)
    else $error("answer without a read");
  a_ques_bits: assert property (p_bits(`ESAH_R_QUES_COND, 32'h235))
    else $error("summary condition has stray bits");
  a_volt_bits: assert property (p_bits(`ESAH_R_VOLT_COND, 32'h7f))
    else $error("voltage condition has stray bits");
  a_temp_bits: assert property (p_bits(`ESAH_R_TEMP_COND, 32'h3fff))
    else $error("temperature condition has stray bits");
  a_time_bits: assert property (p_bits(`ESAH_R_TIME_COND, 32'h7))
    else $error("time condition has stray bits");
  a_bp_bits: assert property (p_bits(`ESAH_R_BP_COND, 32'h3ff))
    else $error("backplane condition has stray bits");
  a_irq_cause: assert property (irq_ff |->
    (status_byte_ff & ~$past(status_byte_ff) & sre_ff) != 8'h00)
    else $error("interrupt without an enabled status rise");
  a_filt_zero: assert property (s_clear ##[1:2] s_elapsed |=>
    rsp_ff.rdata == 32'h0)
    else $error("elapsed time not zero after clear");
endmodule : esah_top_asserts

bind esah_top esah_top_asserts i_esah_top_asserts (
  .clock(clock), .rst_n(rst_n), .mainframe_power_on(mainframe_power_on),
  .cmd(cmd), .rsp_ff(rsp_ff), .irq_ff(irq_ff),
  .status_byte_ff(status_byte_ff));

/* File: verif/esah_host.sv */
/* host controller model: one command at a time on the command port.
   assumes the answer is registered on the same edge that takes the command. */
module esah_host (
  input  wire logic                clock,
  output esah_pkg::esah_cmd_t     cmd,
  input  wire esah_pkg::esah_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ns;
  initial cmd = '0;
  task automatic xfer(input logic w, input logic [4:0] s,
                      input logic [31:0] d, output esah_pkg::esah_rsp_t r);
    @(posedge clock);
    #1 cmd = '{req: 1'b1, wr: w, sel: s, wdata: d};
    @(posedge clock);
    #1 r = rsp;
    // released lines show the inverse so stale values are never trusted
    cmd = '{req: 1'b0, wr: ~w, sel: ~s, wdata: ~d};
  endtask : xfer
endmodule : esah_host

/* File: verif/env_status_alarm_hierarchy_bench.sv */
/* self-checking bench: bit layout, latching, hierarchy, interrupt and
   filter timer, driven through the host model's command task.
   assumes SEC_CYCLES shortened to 4 clocks per second. */
module env_status_alarm_hierarchy_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                clock;
  logic                rst_n = 1'b0;
  logic [35:0]         alarm_in = '0;
  logic                power_on = 1'b0;
  esah_pkg::esah_cmd_t cmd;
  esah_pkg::esah_rsp_t rsp;
  logic [7:0]          stb;
  logic [31:0]         fref;
  logic                irq;
  int                  n_errors = 0;
  int                  n_tests = 0;
  int                  n_irq = 0;
  logic [31:0]         a;
  logic [31:0]         b;
  logic [4:0]          s;
  logic [31:0]         e;
  logic [4:0]          zsel [14] = '{5'h01, 5'h02, 5'h04, 5'h05, 5'h07,
    5'h08, 5'h0a, 5'h0b, 5'h0d, 5'h0e, 5'h10, 5'h11, 5'h12, 5'h1b};

  esah_top #(.SEC_CYCLES(4)) i_esah_top (.clock(clock), .rst_n(rst_n),
    .supply_out_tol(alarm_in[6:0]), .slot_rise_over(alarm_in[19:7]),
    .ambient_over(alarm_in[20]), .fan_out_tol(alarm_in[23:21]),
    .present_time_over(alarm_in[24]), .cumulative_time_over(alarm_in[25]),
    .bus_err_over(alarm_in[26]), .sysfail_asserted(alarm_in[27]),
    .acfail_asserted(alarm_in[28]), .iack_over(alarm_in[35:29]),
    .mainframe_power_on(power_on), .stb_other_bits(8'h00), .cmd(cmd),
    .rsp_ff(rsp), .irq_ff(irq), .status_byte_ff(stb), .filt_ref_ff(fref));
  esah_host i_esah_host (.clock(clock), .cmd(cmd), .rsp(rsp));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) if (irq === 1'b1) n_irq++;

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic rd(input logic [4:0] sl, output logic [31:0] d);
    esah_pkg::esah_rsp_t r;
    i_esah_host.xfer(1'b0, sl, 32'h0, r);
    cmp({31'h0, r.valid}, 32'h1);
    d = r.rdata;
  endtask : rd
  task automatic chk(input logic [4:0] sl, input logic [31:0] ex);
    logic [31:0] d;
    rd(sl, d);
    cmp(d, ex);
  endtask : chk
  task automatic wr(input logic [4:0] sl, input logic [31:0] d);
    esah_pkg::esah_rsp_t r;
    i_esah_host.xfer(1'b1, sl, d, r);
  endtask : wr
  task automatic drive(input logic [35:0] v, input logic p, input int n);
    @(posedge clock);
    #1 alarm_in = v;
    power_on = p;
    repeat (n) @(posedge clock);
  endtask : drive

  initial begin
    repeat (16) @(posedge clock);
    #1 rst_n = 1'b1;
    foreach (zsel[i]) chk(zsel[i], 32'h0);
    $display("test reset done");
    for (int i = 0; i < 36; i++) begin
      if (i < 7) {s, e} = {5'h00, 32'h1 << i};
      else if (i < 21) {s, e} = {5'h03, 32'h1 << (i - 7)};
      else if (i < 24) {s, e} = {5'h06, (32'h2 << (i - 21)) | 32'h1};
      else if (i < 26) {s, e} = {5'h09, 32'h1 << (i - 24)};
      else {s, e} = {5'h0c, 32'h1 << (i - 26)};
      drive(36'h1 << i, 1'b0, 5);
      chk(s, e);
      drive('0, 1'b0, 5);
      chk(s, 32'h0);
      chk(s + 5'h1, e);
      chk(s + 5'h1, 32'h0);
    end
    $display("test bit layout done");
    drive(36'h1 << 7, 1'b0, 5);
    chk(5'h04, 32'h1);
    repeat (10) @(posedge clock);
    chk(5'h04, 32'h0);
    drive('0, 1'b0, 5);
    $display("test held condition done");
    wr(5'h11, 32'h10);
    wr(5'h12, 32'h08);
    wr(5'h05, 32'h1);
    drive(36'h1 << 21, 1'b0, 8);
    chk(5'h0f, 32'h0);
    cmp(n_irq, 0);
    drive('0, 1'b0, 5);
    chk(5'h07, 32'h3);
    drive(36'h1 << 7, 1'b0, 8);
    chk(5'h0f, 32'h10);
    chk(5'h13, 32'h8);
    cmp({24'h0, stb}, 32'h8);
    cmp(n_irq, 1);
    chk(5'h10, 32'h10);
    chk(5'h10, 32'h0);
    chk(5'h13, 32'h0);
    chk(5'h04, 32'h1);
    drive('0, 1'b0, 5);
    chk(5'h0f, 32'h0);
    $display("test hierarchy done");
    wr(5'h14, 32'h3);
    drive('0, 1'b1, 5);
    rd(5'h17, a);
    repeat (38) @(posedge clock);
    rd(5'h17, b);
    cmp(b - a, 32'ha);
    chk(5'h09, 32'h4);
    chk(5'h0a, 32'h4);
    chk(5'h0a, 32'h0);
    chk(5'h09, 32'h4);
    drive('0, 1'b0, 8);
    rd(5'h17, a);
    repeat (38) @(posedge clock);
    rd(5'h17, b);
    cmp(b, a);
    wr(5'h16, 32'h0);
    chk(5'h15, 32'h0);
    cmp(fref, a);
    repeat (5) @(posedge clock);
    chk(5'h09, 32'h0);
    drive('0, 1'b1, 5);
    wr(5'h16, 32'h0);
    rd(5'h15, a);
    repeat (38) @(posedge clock);
    rd(5'h15, b);
    cmp(b - a, 32'ha);
    $display("test filter timer done");
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    finish_test();
  end
endmodule : env_status_alarm_hierarchy_bench
